/* File: logic/gain_offset_correction.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module gain_offset_correction
  import gain_offset_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Raw sample stream in
  input  wire logic                s_valid,
  output logic                     s_ready,
  input  wire logic [SAMPLE_W-1:0] s_sample,
  input  wire logic [SLOT_W-1:0]   s_slot,
  // Corrected sample stream out
  output logic                     m_valid,
  input  wire logic                m_ready,
  output logic [SAMPLE_W-1:0]      m_sample,
  output logic [SLOT_W-1:0]        m_slot
);

  localparam int BUF_W  = SAMPLE_W + SLOT_W;
  localparam int DIFF_W = SAMPLE_W + 1;
  localparam int PROD_W = DIFF_W + GAIN_W + 1;
  localparam logic [PROD_W-1:0] ROUND_HALF = 30'h0000_0800;

  // Register state.
  logic [REG_W-1:0]   corr [0:3];
  logic               gain_en;
  logic               offset_en;
  logic               sat_seen;
  logic [COUNT_W-1:0] sample_count;

  // Write channel state.
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0]        w_strb;

  // Address decode.
  logic [3:0] aw_corr_sel;
  logic [3:0] ar_corr_sel;
  for (genvar i = 0; i < 4; i++) begin : g_decode
    assign aw_corr_sel[i] = aw_addr == idx_to_addr(CORR_IDX[i]);
    assign ar_corr_sel[i] = s_axi_araddr == idx_to_addr(CORR_IDX[i]);
  end

  wire aw_is_ctrl   = aw_addr == idx_to_addr(CTRL3_IDX);
  wire aw_is_status = aw_addr == idx_to_addr(STATUS_IDX);
  wire aw_mapped    = aw_is_ctrl || aw_is_status || (|aw_corr_sel);
  wire ar_is_ctrl   = s_axi_araddr == idx_to_addr(CTRL3_IDX);
  wire ar_is_status = s_axi_araddr == idx_to_addr(STATUS_IDX);
  wire ar_mapped    = ar_is_ctrl || ar_is_status || (|ar_corr_sel);

  wire aw_fire   = s_axi_awvalid && s_axi_awready;
  wire w_fire    = s_axi_wvalid && s_axi_wready;
  wire wr_commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire b_fire    = s_axi_bvalid && s_axi_bready;
  wire ar_fire   = s_axi_arvalid && s_axi_arready;
  wire r_fire    = s_axi_rvalid && s_axi_rready;

  // Byte lanes above the 16-bit register are ignored on write.
  wire [REG_W-1:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [REG_W-1:0] wr_bits   = w_data[REG_W-1:0] & lane_mask;

  wire [REG_W-1:0] ctrl_word = REG_W'({gain_en, 12'h000}) |
                               REG_W'({offset_en, 8'h00});
  wire [DATA_W-1:0] status_word = {sample_count, 15'h0000, sat_seen};

  logic [REG_W-1:0] corr_rd;
  always_comb begin
    corr_rd = '0;
    for (int i = 0; i < 4; i++) begin
      if (ar_corr_sel[i]) begin
        corr_rd = corr_rd | corr[i];
      end
    end
  end

  wire [DATA_W-1:0] rd_word = ar_is_ctrl   ? {16'h0000, ctrl_word} :
                              ar_is_status ? status_word :
                              {16'h0000, corr_rd};

  // Write handshake: address and data are taken in either order, the
  // register is updated once both are held, and the response is raised on the same edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        s_axi_wready <= 1'b0;
      end
      if (wr_commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_fire) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_fire) begin
      aw_addr <= s_axi_awaddr;
    end
    if (w_fire) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // Bit 10 is stored as written; software is expected to keep it zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        corr[i] <= CORR_RESET;
      end
      gain_en   <= 1'b0;
      offset_en <= 1'b0;
    end else if (wr_commit) begin
      for (int i = 0; i < 4; i++) begin
        if (aw_corr_sel[i]) begin
          corr[i] <= (corr[i] & ~lane_mask) | wr_bits;
        end
      end
      if (aw_is_ctrl && w_strb[1]) begin
        gain_en   <= w_data[GAIN_EN_BIT];
        offset_en <= w_data[OFFSET_EN_BIT];
      end
    end
  end

  // Read handshake: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= ar_mapped ? rd_word : 32'h0000_0000;
      s_axi_rresp   <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_fire) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Datapath, one combinational stage into the buffer.
  sample_stream_if #(.W(BUF_W)) in_link ();
  sample_stream_if #(.W(BUF_W)) out_link ();

  wire s_fire = s_valid && in_link.ready;

  wire [REG_W-1:0]    sel_reg   = corr[s_slot];
  wire [CODE_W-1:0]   gain_code = sel_reg[GAIN_MSB:GAIN_LSB];
  wire [OFFSET_W-1:0] offset    = sel_reg[OFFSET_MSB:OFFSET_LSB];

  wire [GAIN_W-1:0] gain_lin = gain_en ? GAIN_TABLE[gain_code]
                                       : GAIN_UNITY;
  wire signed [DIFF_W-1:0] offset_sx = offset_en
    ? {{(DIFF_W-OFFSET_W){offset[OFFSET_W-1]}}, offset}
    : '0;
  wire signed [DIFF_W-1:0] diff =
    DIFF_W'($signed({s_sample[SAMPLE_W-1], s_sample}) - offset_sx);
  wire signed [PROD_W-1:0] prod =
    PROD_W'(diff * $signed({1'b0, gain_lin}));
  wire [PROD_W-1:0] rounded = prod + ROUND_HALF;
  wire [PROD_W-GAIN_FRAC-1:0] scaled = rounded[PROD_W-1:GAIN_FRAC];

  // Out-of-range results clip to the sample's full scale.
  wire [PROD_W-GAIN_FRAC-SAMPLE_W:0] top_bits =
    scaled[PROD_W-GAIN_FRAC-1:SAMPLE_W-1];
  wire saturated = !((&top_bits) || !(|top_bits));
  wire [SAMPLE_W-1:0] clip_value = scaled[PROD_W-GAIN_FRAC-1]
                                   ? 14'h2000 : 14'h1FFF;
  wire [SAMPLE_W-1:0] corrected = saturated ? clip_value
                                            : scaled[SAMPLE_W-1:0];

  assign in_link.valid = s_valid;
  assign in_link.data  = {s_slot, corrected};
  assign out_link.ready = m_ready;

  sample_skid_buffer #(.W(BUF_W)) u_buffer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .up      (in_link),
    .down    (out_link)
  );

  assign s_ready  = in_link.ready;
  assign m_valid  = out_link.valid;
  assign m_slot   = out_link.data[BUF_W-1:SAMPLE_W];
  assign m_sample = out_link.data[SAMPLE_W-1:0];

  // Status: sticky clip flag (write one to clear, a new clip wins) and
  // a free-running count of accepted samples.
  wire sat_clear = wr_commit && aw_is_status && w_strb[0] && w_data[SAT_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sat_seen     <= 1'b0;
      sample_count <= '0;
    end else begin
      if (s_fire && saturated) begin
        sat_seen <= 1'b1;
      end else if (sat_clear) begin
        sat_seen <= 1'b0;
      end
      if (s_fire) begin
        sample_count <= sample_count + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_gain_gated: assert property (
    s_fire && !gain_en && !offset_en |-> corrected == s_sample)
    else $error("sample changed with gain and offset disabled");

  a_gain_step: assert property (
    s_fire && gain_en && !offset_en && gain_code == 5'h1F &&
    s_sample == 14'h0400 |-> corrected == 14'h082B)
    else $error("gain code 31 did not give 6.2 dB");

  a_offset_sub: assert property (
    s_fire && offset_en && !gain_en && !saturated |->
    corrected == SAMPLE_W'(s_sample -
      {{(SAMPLE_W-OFFSET_W){offset[OFFSET_W-1]}}, offset}))
    else $error("offset not subtracted while enabled");

  a_offset_sign: assert property (
    s_fire && offset_en && !gain_en && offset == 10'h3FF &&
    s_sample == 14'h0000 |-> corrected == 14'h0001)
    else $error("offset minus one not treated as two's complement");

  a_slot_low: assert property (
    s_fire && (s_slot == SLOT_CONV2_EVEN || s_slot == SLOT_CONV3_ODD) |->
    sel_reg == (s_slot == SLOT_CONV2_EVEN ? corr[0] : corr[1]))
    else $error("wrong register for conv2 even or conv3 odd");

  a_slot_high: assert property (
    s_fire && (s_slot == SLOT_CONV3_EVEN || s_slot == SLOT_CONV4_ODD) |->
    sel_reg == (s_slot == SLOT_CONV3_EVEN ? corr[2] : corr[3]))
    else $error("wrong register for conv3 even or conv4 odd");

  a_out_follows: assert property (
    s_fire && !m_valid |=> m_valid && m_sample == $past(corrected))
    else $error("corrected sample not presented next cycle");

  a_enable_effect: assert property (
    wr_commit && aw_is_ctrl && w_strb[1] && !w_data[GAIN_EN_BIT] |=>
    !gain_en ##1 (!s_fire || gain_lin == GAIN_UNITY))
    else $error("gain still applied after gain enable cleared");

  c_both_on: cover property (s_fire && gain_en && offset_en);
  c_clip: cover property (s_fire && saturated);
  c_stall: cover property (m_valid && !m_ready && s_valid && !s_ready);
  c_write_read: cover property (wr_commit ##[1:8] ar_fire);

endmodule // gain_offset_correction

/* File: logic/gain_offset_pkg.sv */
// How it works
// - Gain code applies only while gain enable set.
// - Gain equals code times 0.2 dB.
// - Offset subtracted only while offset enable set.
// - Offset is two's complement, 14-bit LSB weight.
// - Conv2_even_gain_offset conv2 even, 11h conv3 odd.
// - Conv3_even_gain_offset conv3 even, 13h conv4 odd.
package gain_offset_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int REG_W    = 16;
  localparam int SAMPLE_W = 14;
  localparam int SLOT_W   = 2;
  localparam int GAIN_W   = 14;
  localparam int OFFSET_W = 10;
  localparam int CODE_W   = 5;
  localparam int GAIN_FRAC = 12;
  localparam int COUNT_W  = 16;

  // Printed offsets are register indices; the byte address is four times.
  localparam logic [7:0] CTRL3_IDX  = 8'h03;
  localparam logic [7:0] STATUS_IDX = 8'h20;
  localparam logic [7:0] CORR_IDX [0:3] = '{8'h10, 8'h11, 8'h12, 8'h13};

  // Stream slot numbers, one per correction register in the order above.
  localparam logic [1:0] SLOT_CONV2_EVEN = 2'h0;
  localparam logic [1:0] SLOT_CONV3_ODD  = 2'h1;
  localparam logic [1:0] SLOT_CONV3_EVEN = 2'h2;
  localparam logic [1:0] SLOT_CONV4_ODD  = 2'h3;

  // Field positions.
  localparam int GAIN_EN_BIT   = 12;
  localparam int OFFSET_EN_BIT = 8;
  localparam int GAIN_MSB      = 15;
  localparam int GAIN_LSB      = 11;
  localparam int RESERVED_BIT  = 10;
  localparam int OFFSET_MSB    = 9;
  localparam int OFFSET_LSB    = 0;
  localparam int SAT_BIT       = 0;
  localparam int COUNT_LSB     = 16;

  localparam logic [REG_W-1:0] CORR_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Linear gain 10^(0.2*N/20) with GAIN_FRAC fraction bits, N = 0..31.
  localparam logic [GAIN_W-1:0] GAIN_TABLE [0:31] = '{
    14'h1000, 14'h105F, 14'h10C1, 14'h1125, 14'h118B, 14'h11F4,
    14'h125F, 14'h12CC, 14'h133C, 14'h13AF, 14'h1425, 14'h149D,
    14'h1518, 14'h1595, 14'h1616, 14'h169A, 14'h1720, 14'h17AA,
    14'h1838, 14'h18C8, 14'h195C, 14'h19F3, 14'h1A8E, 14'h1B2C,
    14'h1BCE, 14'h1C74, 14'h1D1D, 14'h1DCC, 14'h1E7D, 14'h1F33,
    14'h1FED, 14'h20AB};
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 14'h1000;

  function automatic logic [ADDR_W-1:0] idx_to_addr(logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

endpackage

/* File: logic/sample_skid_buffer.sv */
`timescale 1ns/1ns
// Two-entry buffer: an output register plus one skid register. Every
// output is a flip-flop, so the ready path is cut between the stages.
module sample_skid_buffer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // Streams
  sample_stream_if.snk up,
  sample_stream_if.src down
);

  logic         out_valid;
  logic [W-1:0] out_data;
  logic         skid_valid;
  logic [W-1:0] skid_data;
  logic         room;

  wire in_fire  = up.valid && room;
  wire out_take = out_valid && down.ready;

  wire next_out_valid = out_take ? (skid_valid || in_fire)
                                 : (out_valid || in_fire);
  wire next_skid_valid = out_take ? 1'b0
                                  : (skid_valid || (in_fire && out_valid));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid  <= 1'b0;
      skid_valid <= 1'b0;
      room       <= 1'b0;
    end else begin
      out_valid  <= next_out_valid;
      skid_valid <= next_skid_valid;
      room       <= !next_skid_valid;
    end
  end

  always_ff @(posedge aclk) begin
    if (out_take) begin
      out_data <= skid_valid ? skid_data : up.data;
    end else if (in_fire && !out_valid) begin
      out_data <= up.data;
    end
    if (in_fire && out_valid && !out_take) begin
      skid_data <= up.data;
    end
  end

  assign up.ready   = room;
  assign down.valid = out_valid;
  assign down.data  = out_data;

endmodule // sample_skid_buffer

/* File: logic/sample_stream_if.sv */
`timescale 1ns/1ns
interface sample_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: verif/gain_offset_correction_bench.sv */
`timescale 1ns/1ns
module gain_offset_correction_bench
  import gain_offset_pkg::*;
();
  logic                aclk = 1'b0;
  logic                aresetn;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  logic [DATA_W-1:0]   wdata, rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp;
  logic                s_valid, s_ready, m_valid, m_ready;
  logic [SAMPLE_W-1:0] s_sample, m_sample;
  logic [SLOT_W-1:0]   s_slot, m_slot;
  logic [REG_W-1:0]    corr [0:3];
  logic                gain_en, off_en, stall;
  logic [31:0]         rng, v;
  int                  error_cnt, total_checks, cycles, acc, pops;
  logic [15:0]         mq [$];
  logic [33:0]         rq [$];
  logic [1:0]          bq [$];

  gain_offset_correction dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_valid(s_valid), .s_ready(s_ready), .s_sample(s_sample),
    .s_slot(s_slot), .m_valid(m_valid), .m_ready(m_ready),
    .m_sample(m_sample), .m_slot(m_slot)
  );

  always #4 aclk = ~aclk;

  function automatic logic [31:0] xorshift();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [7:0] reg_addr(int i);
    return {CORR_IDX[i][5:0], 2'b00};
  endfunction

  // The gain is rebuilt from the dB law here, not from the design's table.
  function automatic logic [13:0] expect_of(logic [13:0] smp, logic [1:0] sl);
    int         d, g, r;
    logic [4:0] n;
    d = int'($signed(smp));
    n = corr[sl][15:11];
    g = 4096;
    if (off_en) d = d - int'($signed(corr[sl][9:0]));
    if (gain_en) g = $rtoi(4096.0 * 10.0 ** (0.01 * n) + 0.5);
    r = (d * g + 2048) >>> 12;
    if (r > 8191) r = 8191;
    if (r < -8192) r = -8192;
    return r[13:0];
  endfunction

  task automatic check(input string what, input logic [33:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Response ready lines stay high, so every answer is taken at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] resp);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bq.push_back(resp);
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    araddr  <= a;
    arvalid <= 1'b1;
    rq.push_back(e);
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask

  task automatic setreg(input int i, input logic [15:0] val);
    corr[i] = val;
    wr(reg_addr(i), {16'h0000, val}, RESP_OKAY);
    rd(reg_addr(i), {RESP_OKAY, 16'h0000, val});
  endtask

  task automatic setctl(input logic g, input logic o);
    gain_en = g;
    off_en  = o;
    wr({CTRL3_IDX[5:0], 2'b00}, {19'h0, g, 3'h0, o, 8'h00}, RESP_OKAY);
  endtask

  // Valid stays up between back-to-back sends; drain lowers it.
  task automatic send(input logic [13:0] smp, input logic [1:0] sl);
    s_valid  <= 1'b1;
    s_sample <= smp;
    s_slot   <= sl;
    do @(posedge aclk); while (!s_ready);
    mq.push_back({sl, expect_of(smp, sl)});
  endtask

  task automatic drain();
    s_valid <= 1'b0;
    while (mq.size() != 0) @(posedge aclk);
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
    if (aresetn && m_valid && m_ready) begin
      if (mq.size() == 0) check("m_extra", 34'h1, 34'h0);
      else begin
        pops++;
        check("m_out", {18'h0, m_slot, m_sample}, {18'h0, mq.pop_front()});
      end
    end
    if (aresetn && bvalid && bq.size() != 0)
      check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (aresetn && rvalid && rq.size() != 0)
      check("rdata", {rresp, rdata}, rq.pop_front());
    v = xorshift();
    m_ready <= ~stall & (v[0] | v[1]);
  end

  initial begin
    rng = 32'hc30d_a84b;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, arvalid, s_valid, m_ready, stall} = '0;
    {s_sample, s_slot} = '0;
    bready  = 1'b1;
    rready  = 1'b1;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      corr[i] = CORR_RESET;
      rd(reg_addr(i), {RESP_OKAY, 32'h0000_0000});
    end
    rd({CTRL3_IDX[5:0], 2'b00}, {RESP_OKAY, 32'h0000_0000});
    wr(8'h50, 32'h0000_FFFF, RESP_SLVERR);
    rd(8'h50, {RESP_SLVERR, 32'h0000_0000});
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 4; i++) begin
        v = xorshift();
        setreg(i, {v[15:11], 1'b0, v[9:0]});
      end
      setctl(m[1], m[0]);
      for (int k = 0; k < 40; k++) begin
        v = xorshift();
        send(v[13:0], v[15:14]);
      end
      send(14'h1FFF, SLOT_CONV3_ODD);
      send(14'h2000, SLOT_CONV4_ODD);
      drain();
    end
    setctl(1'b1, 1'b0);
    for (int n = 0; n < 32; n++) begin
      setreg(0, {n[4:0], 11'h000});
      send(14'h0400, SLOT_CONV2_EVEN);
      send(14'h3C00, SLOT_CONV2_EVEN);
      drain();
    end
    setctl(1'b0, 1'b1);
    setreg(2, 16'h0200);
    send(14'h1FFF, SLOT_CONV3_EVEN);
    send(14'h2000, SLOT_CONV3_EVEN);
    drain();
    setreg(2, 16'h01FF);
    send(14'h2000, SLOT_CONV3_EVEN);
    drain();
    // Receiver stalls: exactly two words may be held before refusal.
    stall = 1'b1;
    repeat (2) @(posedge aclk);
    acc = 0;
    s_valid  <= 1'b1;
    s_sample <= 14'h0123;
    s_slot   <= SLOT_CONV2_EVEN;
    repeat (6) begin
      @(posedge aclk);
      if (s_ready) begin
        acc++;
        mq.push_back({SLOT_CONV2_EVEN, expect_of(14'h0123, 2'h0)});
      end
    end
    check("accepted", 34'(acc), 34'd2);
    stall = 1'b0;
    do @(posedge aclk); while (!s_ready);
    mq.push_back({SLOT_CONV2_EVEN, expect_of(14'h0123, 2'h0)});
    drain();
    // A clip happened in the offset test, so the sticky flag must be set.
    rd({STATUS_IDX[5:0], 2'b00}, {RESP_OKAY, pops[15:0], 15'h0000, 1'b1});
    wr({STATUS_IDX[5:0], 2'b00}, 32'h0000_0001, RESP_OKAY);
    rd({STATUS_IDX[5:0], 2'b00}, {RESP_OKAY, pops[15:0], 16'h0000});
    report_and_stop();
  end
endmodule // gain_offset_correction_bench
